// ==== core/cpt_pkg.sv ====
// shared types and constants for the configurable pwm/capture timer
package cpt_pkg;

    // ************************************************************
    // sizes and rates
    // ************************************************************
    localparam int CNT_W = 16;
    localparam int PSC_W = 16;
    localparam int DT_W = 8;
    localparam int NCH_MAX = 4;
    localparam int CLK_HZ = 20_000_000;
    // highest counter clock the timers are built for
    localparam int MAX_CNT_CLK_HZ = 64_000_000;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [PSC_W-1:0] PSC_RST = 16'h0000;
    localparam logic [DT_W-1:0] DT_RST = 8'h00;

    // ************************************************************
    // enumerations
    // ************************************************************
    typedef enum logic [2:0] {
        VAR_ADV, VAR_FULL, VAR_SINGLE, VAR_COMP_A, VAR_COMP_B
    } cpt_variant_e;

    typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_CENTER} cpt_dir_e;

    typedef enum logic [1:0] {TRG_NONE, TRG_START, TRG_GATE, TRG_CLOCK} cpt_trig_e;

    typedef enum logic [1:0] {CH_OFF, CH_CAPTURE, CH_COMPARE, CH_PWM} cpt_chmode_e;

    // ************************************************************
    // configuration carriers
    // ************************************************************
    typedef struct packed {
        logic cen;
        cpt_dir_e dir;
        logic opm;
        logic freeze_en;
        cpt_trig_e trig;
        logic enc_en;
        logic [PSC_W-1:0] psc;
        logic [CNT_W-1:0] arr;
        logic [DT_W-1:0] dead;
    } cpt_ctl_s;

    typedef struct packed {
        cpt_chmode_e mode;
        logic [CNT_W-1:0] ccr;
    } cpt_ch_s;

endpackage

// ==== core/cpt_timer.sv ====
// configurable 16-bit timer with prescaler, channels, dead time and encoder
// Summary of operation
// RL1 - full timer: 16-bit auto-reload counter, prescaler
// RL2 - prescaler divides by one to 65536
// RL3 - up/down/center counting; single variants up only
// RL4 - four channels: capture, compare, PWM, one-pulse
// RL5 - edge/center PWM, duty from 0 to 100%
// RL6 - three complementary pairs with dead time
// RL7 - debug halt freezes advanced timer, outputs off; the code does this only when freeze is enabled
// RL8 - debug halt with freeze holds counter
// RL9 - trigger link starts, gates or clocks timer
// RL10 - DMA request on events, not single variant
// RL11 - full timer counts quadrature encoder inputs
// RL12 - complementary single: one channel, one complement
// RL13 - counter clock up to 64 MHz
// RL14 - wrap reloads, sets update flag, requests DMA
// RL15 - one-pulse mode stops after first update
`timescale 1ns/10ps

module cpt_timer #(
    parameter cpt_pkg::cpt_variant_e VARIANT = cpt_pkg::VAR_ADV
) (
    input wire logic clk,
    input wire logic rst,
    input wire cpt_pkg::cpt_ctl_s ctl,
    input wire cpt_pkg::cpt_ch_s [3:0] ch_cfg,
    input wire logic dbg_halt,
    input wire logic trig_in,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic [3:0] ch_in,
    input wire logic uif_clr,
    input wire logic [3:0] cc_clr,
    output logic [15:0] cnt,
    output logic running,
    output logic uif,
    output logic [3:0] cc_flag,
    output logic [3:0][15:0] cap_val,
    output logic [3:0] oc,
    output logic [3:0] ocn,
    output logic dma_req,
    output logic trig_out
);

    // ************************************************************
    // variant features
    // ************************************************************
    localparam bit IS_ADV = (VARIANT == cpt_pkg::VAR_ADV);
    localparam bit IS_FULL = (VARIANT == cpt_pkg::VAR_FULL);
    localparam bit UPDOWN = IS_ADV || IS_FULL; // RL3
    localparam int NCH = UPDOWN ? 4 : 1; // RL4 RL12
    localparam int NCOMP = IS_ADV ? 3 : (VARIANT == cpt_pkg::VAR_SINGLE) ? 0 : 1; // RL6 RL12
    localparam bit HAS_DMA = (VARIANT != cpt_pkg::VAR_SINGLE); // RL10

    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] psc_cnt_r;
    logic up_r, up_nxt;
    logic run_r, cen_d_r, trig_d_r, enc_d_r;
    logic uif_r, dma_r, trig_out_r;
    logic frozen_w, gate_ok_w, step_w, advance_w, tick_w, upd_w, enc_w, start_w;
    logic [3:0] cc_ev_w;
    cpt_pkg::cpt_dir_e dir_w;

    // ************************************************************
    // count qualification
    // ************************************************************
    // freeze halts the prescaler too, so the phase resumes cleanly
    assign frozen_w = dbg_halt && ctl.freeze_en; // RL8
    assign enc_w = IS_FULL && ctl.enc_en;
    assign gate_ok_w = (ctl.trig != cpt_pkg::TRG_GATE) || trig_in; // RL9
    // one step per clock at most, so the counter rate stays within limits
    assign step_w = enc_w ? (enc_a && !enc_d_r) : // RL11 RL13
                    (ctl.trig == cpt_pkg::TRG_CLOCK) ? (trig_in && !trig_d_r) : 1'b1; // RL9
    assign advance_w = run_r && !frozen_w && gate_ok_w && step_w;
    assign tick_w = advance_w && (psc_cnt_r == ctl.psc); // RL2
    assign dir_w = !UPDOWN ? cpt_pkg::CNT_UP : // RL3
                   enc_w ? (enc_b ? cpt_pkg::CNT_DOWN : cpt_pkg::CNT_UP) : ctl.dir; // RL11
    assign start_w = (ctl.trig == cpt_pkg::TRG_START) ? (trig_in && !trig_d_r) // RL9
                                                      : (ctl.cen && !cen_d_r);

    // edge history of link, encoder and enable
    always_ff @(posedge clk) begin
        if (rst) begin
            cen_d_r <= 1'b0;
            trig_d_r <= 1'b0;
            enc_d_r <= 1'b0;
        end else begin
            cen_d_r <= ctl.cen;
            trig_d_r <= trig_in;
            enc_d_r <= enc_a;
        end
    end

    // prescaler: divides by psc + 1
    always_ff @(posedge clk) begin
        if (rst) begin
            psc_cnt_r <= cpt_pkg::PSC_RST;
        end else if (advance_w) begin
            psc_cnt_r <= tick_w ? cpt_pkg::PSC_RST : 16'(psc_cnt_r + 16'h0001); // RL2
        end
    end

    // ************************************************************
    // counter and update event
    // ************************************************************
    // wrap detection uses >= so a shrunk reload value cannot strand the count
    always_comb begin
        cnt_nxt = cnt_r;
        up_nxt = up_r;
        upd_w = 1'b0;
        if (tick_w) begin
            unique case (dir_w)
                cpt_pkg::CNT_UP: begin
                    if (cnt_r >= ctl.arr) begin
                        cnt_nxt = cpt_pkg::CNT_RST; // RL1 RL14
                        upd_w = 1'b1;
                    end else begin
                        cnt_nxt = 16'(cnt_r + 16'h0001);
                    end
                end
                cpt_pkg::CNT_DOWN: begin
                    if (cnt_r == 16'h0000 || cnt_r > ctl.arr) begin
                        cnt_nxt = ctl.arr; // RL14
                        upd_w = 1'b1;
                    end else begin
                        cnt_nxt = 16'(cnt_r - 16'h0001);
                    end
                end
                default: begin
                    // center mode: turn at the reload value and at zero
                    if (up_r && cnt_r >= ctl.arr) begin
                        up_nxt = 1'b0;
                        cnt_nxt = (ctl.arr == 16'h0000) ? 16'h0000 : 16'(ctl.arr - 16'h0001);
                        upd_w = 1'b1; // RL14
                    end else if (up_r) begin
                        cnt_nxt = 16'(cnt_r + 16'h0001);
                    end else if (cnt_r == 16'h0000) begin
                        up_nxt = 1'b1;
                        cnt_nxt = (ctl.arr == 16'h0000) ? 16'h0000 : 16'h0001;
                        upd_w = 1'b1; // RL14
                    end else begin
                        cnt_nxt = 16'(cnt_r - 16'h0001);
                    end
                end
            endcase
        end
    end

    // counter register; only a tick moves it, so freeze holds it
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= cpt_pkg::CNT_RST;
            up_r <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt; // RL8
            up_r <= up_nxt;
        end
    end

    // run control: start on enable edge or link trigger, stop after one pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            run_r <= 1'b0;
        end else if (!ctl.cen) begin
            run_r <= 1'b0;
        end else if (!run_r && start_w) begin
            run_r <= 1'b1; // RL9
        end else if (upd_w && ctl.opm) begin
            run_r <= 1'b0; // RL15
        end
    end

    // sticky update flag; a new update beats the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            uif_r <= 1'b0;
        end else if (upd_w) begin
            uif_r <= 1'b1; // RL14
        end else if (uif_clr) begin
            uif_r <= 1'b0;
        end
    end

    // dma request and link output, one cycle after the event
    always_ff @(posedge clk) begin
        if (rst) begin
            dma_r <= 1'b0;
            trig_out_r <= 1'b0;
        end else begin
            dma_r <= HAS_DMA && (upd_w || (|cc_ev_w)); // RL10 RL14
            trig_out_r <= upd_w; // RL9
        end
    end

    // ************************************************************
    // channels
    // ************************************************************
    for (genvar i = 0; i < 4; i++) begin : g_ch
        localparam bit ACT = (i < NCH);
        localparam bit COMP = (i < NCOMP);
        logic ref_r, ref_d_r, in_d_r, flag_r, oc_r, ocn_r;
        logic [15:0] cap_r;
        logic [7:0] dt_r;
        logic drive_w, cap_ev_w;

        assign drive_w = ACT && (ch_cfg[i].mode inside {cpt_pkg::CH_COMPARE, cpt_pkg::CH_PWM});
        assign cap_ev_w = ACT && ch_cfg[i].mode == cpt_pkg::CH_CAPTURE && ch_in[i] && !in_d_r;
        assign cc_ev_w[i] = cap_ev_w || (drive_w && tick_w && cnt_r == ch_cfg[i].ccr);

        // reference waveform; in pwm outside one-pulse, ccr 0 gives constant low, ccr above reload constant high
        always_ff @(posedge clk) begin
            if (rst || !drive_w) begin
                ref_r <= 1'b0;
            end else if (ch_cfg[i].mode == cpt_pkg::CH_COMPARE) begin
                if (tick_w && cnt_r == ch_cfg[i].ccr) begin
                    ref_r <= !ref_r; // RL4
                end
            end else if (ctl.opm) begin
                ref_r <= run_r && cnt_r >= ch_cfg[i].ccr; // RL15
            end else begin
                ref_r <= cnt_r < ch_cfg[i].ccr; // RL5
            end
        end

        // input capture and sticky channel flag; set wins over clear
        always_ff @(posedge clk) begin
            if (rst) begin
                in_d_r <= 1'b0;
                cap_r <= cpt_pkg::CNT_RST;
                flag_r <= 1'b0;
            end else begin
                in_d_r <= ch_in[i];
                if (cap_ev_w) begin
                    cap_r <= cnt_r; // RL4
                end
                if (cc_ev_w[i]) begin
                    flag_r <= 1'b1;
                end else if (cc_clr[i]) begin
                    flag_r <= 1'b0;
                end
            end
        end

        // dead-time counter restarts on every reference edge of a complementary channel
        always_ff @(posedge clk) begin
            if (rst) begin
                ref_d_r <= 1'b0;
                dt_r <= cpt_pkg::DT_RST;
            end else begin
                ref_d_r <= ref_r;
                if (COMP && ref_r != ref_d_r) begin
                    dt_r <= ctl.dead; // RL6
                end else if (dt_r != 8'h00) begin
                    dt_r <= 8'(dt_r - 8'h01);
                end
            end
        end

        // pin drivers: both legs low during dead time and debug off-state
        always_ff @(posedge clk) begin
            if (rst || !drive_w || (IS_ADV && frozen_w)) begin // RL7
                oc_r <= 1'b0;
                ocn_r <= 1'b0;
            end else if (COMP && ((ref_r != ref_d_r && ctl.dead != 8'h00) || dt_r > 8'h01)) begin
                oc_r <= 1'b0; // RL6
                ocn_r <= 1'b0;
            end else begin
                oc_r <= ref_r;
                ocn_r <= COMP && !ref_r; // RL12
            end
        end

        assign oc[i] = oc_r;
        assign ocn[i] = ocn_r;
        assign cc_flag[i] = flag_r;
        assign cap_val[i] = cap_r;

        AST_PWM_ZERO: assert property (@(posedge clk) disable iff (rst) // RL5
            drive_w && ch_cfg[i].mode == cpt_pkg::CH_PWM && !ctl.opm && ch_cfg[i].ccr == 16'h0000
            |=> !ref_r) else $error("pwm with zero compare not low");
        if (COMP) begin : g_dt_chk
            AST_DEAD_GAP: assert property (@(posedge clk) disable iff (rst) // RL6
                drive_w && ref_r != ref_d_r && ctl.dead != 8'h00 |=> !oc_r && !ocn_r)
                else $error("complementary pair not both off at edge");
        end
    end

    assign cnt = cnt_r;
    assign running = run_r;
    assign uif = uif_r;
    assign dma_req = dma_r;
    assign trig_out = trig_out_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wrap_up;
        tick_w && dir_w == cpt_pkg::CNT_UP && cnt_r >= ctl.arr;
    endsequence
    sequence s_wrap_down;
        tick_w && dir_w == cpt_pkg::CNT_DOWN && cnt_r == 16'h0000;
    endsequence
    sequence s_reloaded_up;
        cnt_r == 16'h0000 && uif_r;
    endsequence

    AST_FREEZE_HOLD: assert property (frozen_w |=> $stable(cnt_r)) // RL8
        else $error("counter moved while frozen");
    AST_ADV_OFF: assert property (IS_ADV && frozen_w |=> oc == 4'h0 && ocn == 4'h0) // RL7
        else $error("advanced outputs active in debug halt");
    AST_RELOAD_UP: assert property (s_wrap_up |=> s_reloaded_up) // RL14
        else $error("up wrap did not reload to zero");
    AST_RELOAD_DOWN: assert property (s_wrap_down |=> cnt_r == $past(ctl.arr) && uif_r) // RL3
        else $error("down wrap did not reload");
    AST_OPM_STOP: assert property (upd_w && ctl.opm |=> !run_r ##1 !run_r || start_w) // RL15
        else $error("one-pulse did not stop");
    AST_PSC_STEP: assert property (advance_w && psc_cnt_r < ctl.psc // RL2
        |=> psc_cnt_r == 16'($past(psc_cnt_r) + 16'h0001) && $stable(cnt_r))
        else $error("prescaler step wrong");
    AST_UIF_STICKY: assert property (uif_r && !uif_clr |=> uif_r) // RL14
        else $error("update flag lost");
    AST_DMA_REQ: assert property (upd_w |=> dma_req == HAS_DMA) // RL10
        else $error("dma request mismatch on update");
    AST_SINGLE_UP: assert property (!UPDOWN && tick_w && cnt_r < ctl.arr // RL3
        |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
        else $error("single-channel variant did not count up");

endmodule

// ==== tb/cpt_pin_model.sv ====
// pin-side model: capture signal source and power-switch pair watcher
`timescale 1ns/10ps

module cpt_pin_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] oc,
    input wire logic [3:0] ocn,
    input wire logic [cpt_pkg::DT_W-1:0] dead,
    output logic [3:0] ch_in,
    output int faults
);
    int off_n [3];
    logic [3:0] oc_q;
    logic [3:0] ocn_q;

    initial ch_in = 4'h0;
    initial faults = 0;

    // source holds its level a few clocks so the edge sampler cannot miss it
    task automatic pulse(input int k);
        @(negedge clk);
        ch_in[k] = 1'b1;
        repeat (3) @(negedge clk);
        ch_in[k] = 1'b0;
    endtask

    // a switch pair must never conduct together, and must rest dead clocks between
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (!rst && oc[i] && ocn[i]) faults++;
            if (!rst && dead != 8'h00 && ((oc[i] && !oc_q[i]) || (ocn[i] && !ocn_q[i])) &&
                off_n[i] < dead) faults++;
            // large after reset so the first turn-on is never blamed
            if (rst) off_n[i] <= 1000;
            else if (oc[i] || ocn[i]) off_n[i] <= 0;
            else off_n[i] <= off_n[i] + 1;
        end
        oc_q <= oc;
        ocn_q <= ocn;
    end
endmodule

// ==== tb/test_configurable_pwm_capture_timer.sv ====
// self-checking bench for the configurable pwm/capture timer
`timescale 1ns/10ps

module test_configurable_pwm_capture_timer;
    logic clk = 1'b0;
    logic rst = 1'b1;
    cpt_pkg::cpt_ctl_s ctl = '0;
    cpt_pkg::cpt_ch_s [3:0] ch_cfg = '0;
    logic dbg_halt = 1'b0;
    logic trig_in = 1'b0;
    logic enc_a = 1'b0;
    logic enc_b = 1'b0;
    logic [15:0] f_cnt;
    logic uif_clr = 1'b0;
    logic [3:0] cc_clr = 4'h0;
    logic [3:0] ch_in, cc_flag, oc, ocn;
    logic [15:0] cnt;
    logic running, uif, dma_req, trig_out, s_dma;
    logic [3:0][15:0] cap_val;
    logic [15:0] seed_r = 16'h004F;
    int num_errors = 0;
    int n_tests = 0;
    int pm_faults, s_hits, n, snap, ex, ccr;

    // ********************************
    // clock, design and pin model
    // ********************************
    always #25 clk = ~clk;

    cpt_timer #(.VARIANT(cpt_pkg::VAR_ADV)) uut (.clk(clk), .rst(rst), .ctl(ctl),
        .ch_cfg(ch_cfg), .dbg_halt(dbg_halt), .trig_in(trig_in), .enc_a(1'b0), .enc_b(1'b0),
        .ch_in(ch_in), .uif_clr(uif_clr), .cc_clr(cc_clr), .cnt(cnt), .running(running),
        .uif(uif), .cc_flag(cc_flag), .cap_val(cap_val), .oc(oc), .ocn(ocn),
        .dma_req(dma_req), .trig_out(trig_out));

    // up-only variant without dma sees the same stimulus
    cpt_timer #(.VARIANT(cpt_pkg::VAR_SINGLE)) uut_single (.clk(clk), .rst(rst), .ctl(ctl),
        .ch_cfg(ch_cfg), .dbg_halt(dbg_halt), .trig_in(trig_in), .enc_a(1'b0), .enc_b(1'b0),
        .ch_in(ch_in), .uif_clr(uif_clr), .cc_clr(cc_clr), .cnt(), .running(), .uif(),
        .cc_flag(), .cap_val(), .oc(), .ocn(), .dma_req(s_dma), .trig_out());

    // full variant follows the encoder pins, the others ignore them
    cpt_timer #(.VARIANT(cpt_pkg::VAR_FULL)) uut_full (.clk(clk), .rst(rst), .ctl(ctl),
        .ch_cfg(ch_cfg), .dbg_halt(dbg_halt), .trig_in(trig_in), .enc_a(enc_a), .enc_b(enc_b),
        .ch_in(ch_in), .uif_clr(uif_clr), .cc_clr(cc_clr), .cnt(f_cnt), .running(), .uif(),
        .cc_flag(), .cap_val(), .oc(), .ocn(), .dma_req(), .trig_out());

    cpt_pin_model pm (.clk(clk), .rst(rst), .oc(oc), .ocn(ocn), .dead(ctl.dead),
        .ch_in(ch_in), .faults(pm_faults));

    initial s_hits = 0;
    always @(negedge clk) if (s_dma === 1'b1) s_hits++;

    // ********************************
    // helpers
    // ********************************
    function automatic logic [15:0] rnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // clocks between updates; center mode updates at both turning points
    function automatic int period(input int d, input int p, input int a);
        return (p + 1) * ((d == 2) ? a : a + 1);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // caller sets ctl first; enable rises one clock after release
    task automatic start();
        rst = 1'b1;
        ctl.cen = 1'b0;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        ctl.cen = 1'b1;
    endtask

    task automatic wait_up();
        for (int i = 0; i < 3000 && trig_out !== 1'b1; i++) cyc(1);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // hang guard, well beyond the few hundred clocks the tests need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out();
    end

    // ********************************
    // tests
    // ********************************
    initial begin
        cyc(2);
        rst = 1'b0;
        chk({cnt, uif, running, oc, ocn, dma_req}, 32'h0);
        $display("test reset done");
        // period, update flag and dma for every direction
        for (int d = 0; d < 3; d++) begin
            seed_r = rnd(seed_r);
            ctl = '0;
            ctl.dir = cpt_pkg::cpt_dir_e'(d);
            ctl.psc = {14'h0000, seed_r[1:0]};
            ctl.arr = {13'h0000, seed_r[4:2]} + 16'h0002;
            start();
            wait_up();
            wait_up();
            chk(dma_req, 1'b1);
            chk(uif, 1'b1);
            uif_clr = 1'b1;
            cyc(1);
            uif_clr = 1'b0;
            chk(uif, 1'b0);
            n = 1;
            while (trig_out !== 1'b1 && n < 3000) begin
                cyc(1);
                n++;
            end
            chk(n, period(d, ctl.psc, ctl.arr));
        end
        $display("test periods done");
        // duty at both extremes and in between
        for (int k = 0; k < 3; k++) begin
            seed_r = rnd(seed_r);
            ctl = '0;
            ctl.arr = {13'h0000, seed_r[2:0]} + 16'h0004;
            ccr = (k == 0) ? 0 : (k == 1) ? 1 + seed_r[4:3] : ctl.arr + 1;
            ch_cfg = '0;
            ch_cfg[0].mode = cpt_pkg::CH_PWM;
            ch_cfg[0].ccr = ccr[15:0];
            start();
            wait_up();
            cyc(3);
            n = 0;
            for (int i = 0; i <= ctl.arr; i++) begin
                if (oc[0] === 1'b1) n++;
                cyc(1);
            end
            ex = (k == 2) ? ctl.arr + 1 : ccr;
            chk(n, ex);
        end
        $display("test duty done");
        // complementary pair with a dead gap
        ctl = '0;
        ctl.arr = 16'h0007;
        ctl.dead = 8'h03;
        ch_cfg[0].ccr = 16'h0002;
        start();
        cyc(80);
        chk(pm_faults, 0);
        $display("test dead time done");
        // debug freeze, then capture while frozen
        ctl = '0;
        ctl.arr = 16'h0FFF;
        ctl.freeze_en = 1'b1;
        ch_cfg[0].ccr = 16'hFFFF;
        ch_cfg[1].mode = cpt_pkg::CH_CAPTURE;
        start();
        cyc(20);
        chk(oc[0], 1'b1);
        dbg_halt = 1'b1;
        cyc(2);
        snap = cnt;
        cyc(8);
        chk(cnt, snap);
        chk({oc, ocn}, 8'h00);
        pm.pulse(1);
        cyc(3);
        chk(cap_val[1], snap);
        chk(cc_flag[1], 1'b1);
        cc_clr = 4'h2;
        cyc(1);
        cc_clr = 4'h0;
        cyc(1);
        chk(cc_flag[1], 1'b0);
        dbg_halt = 1'b0;
        cyc(4);
        chk(cnt != snap, 1'b1);
        $display("test freeze done");
        // one pulse stops after the first update
        seed_r = rnd(seed_r);
        ctl = '0;
        ctl.opm = 1'b1;
        ctl.arr = {13'h0000, seed_r[2:0]} + 16'h0003;
        start();
        cyc(2);
        for (int i = 0; i < 500 && running !== 1'b0; i++) cyc(1);
        snap = cnt;
        cyc(10);
        chk({running, uif}, 2'b01);
        chk(cnt, snap);
        $display("test one pulse done");
        // link trigger starts the counter
        ctl = '0;
        ctl.trig = cpt_pkg::TRG_START;
        ctl.arr = 16'h0005;
        start();
        cyc(5);
        chk(running, 1'b0);
        trig_in = 1'b1;
        cyc(2);
        trig_in = 1'b0;
        chk(running, 1'b1);
        // gate mode with the link low must hold the count
        ctl.trig = cpt_pkg::TRG_GATE;
        cyc(1);
        snap = cnt;
        cyc(5);
        chk(cnt, snap);
        trig_in = 1'b1;
        cyc(3);
        trig_in = 1'b0;
        chk(cnt != snap, 1'b1);
        chk(s_hits, 0);
        $display("test trigger done");
        // quadrature counting: random steps up, then fewer steps down
        seed_r = rnd(seed_r);
        ctl = '0;
        ctl.enc_en = 1'b1;
        ctl.arr = 16'h00FF;
        start();
        cyc(1);
        n = 4 + seed_r[3:0];
        ex = 1 + seed_r[5:4];
        for (int i = 0; i < n + ex; i++) begin
            enc_b = (i >= n);
            enc_a = 1'b1;
            cyc(1);
            enc_a = 1'b0;
            cyc(1);
        end
        chk(f_cnt, n - ex);
        $display("test encoder done");
        close_out();
    end
endmodule
